// >>> hw/bpcci_top.sv
// How it works
// - Two adjacent even-aligned ports in 256 space
// - Control port at base plus one
// - A7..A1 compared against seven switches
// - Switch on means zero, off one
// - Default base address is 240
// - Write protect blocks all time writes; the time keeps counting
// - Periodic ticks: minute, second, 1/64, 1/1024
// - Tick routed to eight levels or NMI
// - Slave only, 8-bit data and address
// - Keeps date, weekday, hour format, time
// - Time counts from 32.768 kHz reference
// - Data register and control register exposed
// - Core access stalls bus 150 us
// - Read freezes readout half second while time runs; clear releases
`timescale 1ns/100ps
`include "bpcci_consts.svh"
module bpcci_top #(
    parameter int unsigned ACCESS_CYC   = `BPCCI_ACCESS_CYC,
    parameter int unsigned FREEZE_TICKS = `BPCCI_FREEZE_TICKS
) (
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    input  wire bpcci_pkg::bpcci_req_t req,
    input  wire bpcci_pkg::bpcci_cfg_t cfg,
    input  wire logic              xtal_in,
    output logic [7:0]             rdata,
    output logic                   rdata_oe,
    output logic                   rdy,
    output logic [7:0]             irq_vi,
    output logic                   irq_nmi
);
    bpcci_pkg::bpcci_state_t state_q;
    logic [7:0]  ctrl_q;
    logic [7:0]  data_q;
    logic [15:0] wait_q;
    logic [2:0]  xs_q;
    logic [12:0] cin;
    logic [15:0] div_q;
    logic [15:0] frz_q;
    logic        sec_tick;
    logic        sel;
    logic        hit_data;
    logic        hit_ctrl;
    logic [3:0]  dig [0:12];
    logic [3:0]  snap [0:12];
    logic [12:0] roll;
    logic        tick_sel;
    logic [5:0]  min_div_q;

    // Switch off reads as 1, so a bit matches when address equals negated switch
    assign sel      = (req.addr[7:1] == ~cfg.base_sw_n);
    assign hit_data = sel && (req.addr[0] == `BPCCI_DATA_OFS);
    assign hit_ctrl = sel && (req.addr[0] == `BPCCI_CTRL_OFS);

    // Crystal passes three flops; edge counts when the last two agree
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            xs_q <= 3'h0;
        end else begin
            xs_q <= {xs_q[1:0], xtal_in};
        end
    end
    logic xlvl_q;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            xlvl_q <= 1'b0;
        end else if (xs_q[1] == xs_q[2]) begin
            xlvl_q <= xs_q[2];
        end
    end
    logic xrise;
    assign xrise = (xs_q[1] == xs_q[2]) && xs_q[2] && !xlvl_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            div_q <= 16'h0000;
        end else if (xrise) begin
            div_q <= (div_q == 16'(`BPCCI_TICK_SEC - 1)) ? 16'h0000 : div_q + 16'h0001;
        end
    end
    assign sec_tick = xrise && (div_q == 16'(`BPCCI_TICK_SEC - 1));

    // Freeze: the snapshot holds while the counter runs; time itself keeps counting
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            frz_q <= 16'h0000;
        end else if (req.wr && hit_ctrl && req.wdata == `BPCCI_CODE_CLEAR) begin
            frz_q <= 16'h0000;
        end else if (req.rd && hit_data && frz_q == 16'h0000) begin
            frz_q <= 16'(FREEZE_TICKS);
        end else if (xrise && frz_q != 16'h0000) begin
            frz_q <= frz_q - 16'h0001;
        end
    end

    // Digit counters, BCD with carry; limits kept simple (no month length table)
    function automatic logic [3:0] lim(input int i, input logic [3:0] t);
        case (i)
            0, 2, 7, 9, 11: lim = 4'h9;
            1, 3:           lim = 4'h5;
            4:              lim = (t[1]) ? 4'h3 : 4'h9;
            5:              lim = 4'h2;
            6:              lim = 4'h6;
            8:              lim = 4'h3;
            10:             lim = 4'h1;
            default:        lim = 4'h9;
        endcase
    endfunction

    // Weekday sits beside the chain and only takes the midnight carry
    always_comb begin
        for (int i = 0; i < 13; i++) begin
            if (i == 5 || i == 8 || i == 10) begin
                roll[i] = dig[i][1:0] >= 2'(lim(i, dig[5]));
            end else begin
                roll[i] = dig[i] >= lim(i, dig[5]);
            end
        end
        cin[0] = 1'b1;
        for (int i = 0; i < 12; i++) begin
            cin[i+1] = (i == 6) ? cin[i] : (cin[i] && roll[i]);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 13; i++) dig[i] <= 4'h0;
        end else if (req.wr && hit_ctrl && req.wdata[`BPCCI_WRITE_BIT] &&
                     req.wdata[3:0] <= `BPCCI_CODE_LAST_DIGIT && cfg.wp_n) begin
            dig[req.wdata[3:0]] <= data_q[3:0];
        end else if (sec_tick) begin
            for (int i = 0; i < 13; i++) begin
                if (cin[i] && i != 6) begin
                    if (roll[i]) begin
                        dig[i] <= (i == 5 || i == 8) ? {dig[i][3:2], 2'h0} : 4'h0;
                    end else begin
                        dig[i] <= dig[i] + 4'h1;
                    end
                end
            end
            if (cin[6]) begin
                dig[6] <= (dig[6] == 4'h6) ? 4'h0 : dig[6] + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 13; i++) snap[i] <= 4'h0;
        end else if (frz_q == 16'h0000) begin
            for (int i = 0; i < 13; i++) snap[i] <= dig[i];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= 8'h00;
            data_q <= 8'h00;
        end else if (req.wr && hit_ctrl) begin
            ctrl_q <= req.wdata;
        end else if (req.wr && hit_data) begin
            data_q <= req.wdata;
        end
    end

    // Bus stall for each core access
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= bpcci_pkg::BPCCI_IDLE;
            wait_q  <= 16'h0000;
            rdy     <= 1'b1;
        end else begin
            unique case (state_q)
                bpcci_pkg::BPCCI_IDLE: begin
                    if ((req.rd && hit_data) || (req.wr && hit_ctrl && req.wdata[`BPCCI_WRITE_BIT])) begin
                        state_q <= bpcci_pkg::BPCCI_WAIT;
                        wait_q  <= 16'(ACCESS_CYC - 1);
                        rdy     <= 1'b0;
                    end
                end
                bpcci_pkg::BPCCI_WAIT: begin
                    if (wait_q == 16'h0000) begin
                        state_q <= bpcci_pkg::BPCCI_DONE;
                        rdy     <= 1'b1;
                    end else begin
                        wait_q <= wait_q - 16'h0001;
                    end
                end
                bpcci_pkg::BPCCI_DONE: begin
                    if (!req.rd && !req.wr) state_q <= bpcci_pkg::BPCCI_IDLE;
                end
                default: state_q <= bpcci_pkg::BPCCI_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata    <= 8'h00;
            rdata_oe <= 1'b0;
        end else begin
            rdata_oe <= req.rd && hit_data;
            rdata    <= (ctrl_q[3:0] <= `BPCCI_CODE_LAST_DIGIT) ? {4'h0, snap[ctrl_q[3:0]]} : 8'h00;
        end
    end

    // Periodic tick, one clock wide, on the chosen interval
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            min_div_q <= 6'h00;
        end else if (sec_tick) begin
            min_div_q <= (min_div_q == 6'h3b) ? 6'h00 : min_div_q + 6'h01;
        end
    end
    always_comb begin
        unique case (cfg.irq_rate)
            2'b00: tick_sel = sec_tick && min_div_q == 6'h3b;
            2'b01: tick_sel = sec_tick;
            2'b10: tick_sel = xrise && div_q[8:0] == 9'(`BPCCI_TICK_64 - 1);
            2'b11: tick_sel = xrise && div_q[4:0] == 5'(`BPCCI_TICK_1024 - 1);
        endcase
    end
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_vi  <= 8'h00;
            irq_nmi <= 1'b0;
        end else begin
            irq_vi  <= (tick_sel && !cfg.irq_route[3]) ? (8'h01 << cfg.irq_route[2:0]) : 8'h00;
            irq_nmi <= tick_sel && cfg.irq_route[3];
        end
    end
endmodule

// >>> pkg/bpcci_consts.svh
`ifndef BPCCI_CONSTS_SVH
`define BPCCI_CONSTS_SVH
`define BPCCI_DATA_OFS         1'h0
`define BPCCI_CTRL_OFS         1'h1
`define BPCCI_BASE_SW_DEFAULT  7'h07
`define BPCCI_WRITE_BIT        4
`define BPCCI_CODE_CLEAR       8'h20
`define BPCCI_CODE_LAST_DIGIT  4'hc
`define BPCCI_CLK_HZ           10000000
`define BPCCI_XTAL_HZ          32768
`define BPCCI_ACCESS_US        150
`define BPCCI_ACCESS_CYC       ((`BPCCI_ACCESS_US * (`BPCCI_CLK_HZ / 1000000)))
`define BPCCI_FREEZE_TICKS     (`BPCCI_XTAL_HZ / 2)
`define BPCCI_TICK_1024        32
`define BPCCI_TICK_64          512
`define BPCCI_TICK_SEC         32768
`endif

// >>> pkg/bpcci_pkg.sv
package bpcci_pkg;
    typedef enum logic [1:0] {
        BPCCI_IDLE  = 2'b00,
        BPCCI_WAIT  = 2'b01,
        BPCCI_DONE  = 2'b10
    } bpcci_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bpcci_req_t;

    typedef struct packed {
        logic [6:0] base_sw_n;
        logic       wp_n;
        logic [1:0] irq_rate;
        logic [3:0] irq_route;
    } bpcci_cfg_t;
endpackage

// >>> tb/bpcci_host.sv
`timescale 1ns/100ps
module bpcci_host (
    input  wire logic             clk_sys,
    input  wire logic             rdy,
    input  wire logic [7:0]       rdata,
    input  wire logic             rdata_oe,
    output bpcci_pkg::bpcci_req_t req
);
    initial req = '0;
    // Strobe held until rdy seen high; lo of -1 flags a hang
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic oe, output int lo);
        int n;
        n = 0;
        lo = 0;
        oe = 0;
        q = 8'h00;
        @(negedge clk_sys);
        req = '{addr: a, wdata: d, wr: w, rd: !w};
        do begin
            @(negedge clk_sys);
            n++;
            lo += int'(!rdy);
            oe |= rdata_oe;
            q = rdata_oe ? rdata : q;
        end while ((!rdy || n < 3) && n < 3000);
        lo = n >= 3000 ? -1 : lo;
        // Released lines do not keep their last value
        req = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask
endmodule

// >>> tb/bpcci_top_bench.sv
`timescale 1ns/100ps
module bpcci_top_bench;
    localparam int ACC = 4;
    logic                  clk_sys, nrst, xtal_in, rdata_oe, rdy, irq_nmi, oe;
    logic [7:0]            rdata, irq_vi, base, q;
    bpcci_pkg::bpcci_req_t req;
    bpcci_pkg::bpcci_cfg_t cfg;
    int                    lo, error_cnt = 0, cmp_count = 0;
    bpcci_top #(.ACCESS_CYC(ACC), .FREEZE_TICKS(8)) u_bpcci_top (.clk_sys(clk_sys), .nrst(nrst), .req(req),
        .cfg(cfg), .xtal_in(xtal_in), .rdata(rdata), .rdata_oe(rdata_oe), .rdy(rdy), .irq_vi(irq_vi),
        .irq_nmi(irq_nmi));
    bpcci_host u_bpcci_host (.clk_sys(clk_sys), .rdy(rdy), .rdata(rdata), .rdata_oe(rdata_oe), .req(req));
    initial begin
        clk_sys = 0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Crystal sped up to ten clocks a tick to keep the run short
    initial begin
        xtal_in = 0;
        forever #500 xtal_in = ~xtal_in;
    end
    task automatic give_verdict;
        $display("counts: compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        u_bpcci_host.acc(w, a, d, q, oe, lo);
        if (lo < 0) begin
            error_cnt++;
            give_verdict();
        end
    endtask
    task automatic rd_dig(input logic [7:0] c, input logic [3:0] e);
        xfer(1'b1, base + 8'h01, c);
        xfer(1'b0, base, 8'h00);
        chk(32'(q[3:0]), 32'(e));
        chk(32'(oe), 32'h1);
        chk(32'(lo >= ACC - 1 && lo <= ACC + 1), 32'h1);
    endtask
    task automatic wr_dig(input logic [7:0] c, input logic [3:0] v);
        xfer(1'b1, base, {4'h0, v});
        xfer(1'b1, base + 8'h01, c + 8'h10);
        xfer(1'b1, base + 8'h01, 8'h20);
    endtask
    task automatic tick(input logic [1:0] rt, input logic [3:0] ro, input int per);
        int t;
        cfg.irq_rate = rt;
        cfg.irq_route = ro;
        for (int k = 0; k < 2; k++) begin
            t = 0;
            do begin
                @(negedge clk_sys);
                t++;
            end while (!(ro[3] ? irq_nmi : irq_vi[ro[2:0]]) && t < per * 25);
            if (t >= per * 25) begin
                error_cnt++;
                give_verdict();
            end
        end
        chk(32'(t >= per * 10 - 2 && t <= per * 10 + 2), 32'h1);
    endtask
    function automatic logic [3:0] dv(input int c);
        return (c == 10) ? 4'h1 : 4'(c % 4);
    endfunction
    initial begin
        nrst = 0;
        cfg = '{base_sw_n: 7'h07, wp_n: 1'b1, irq_rate: 2'h3, irq_route: 4'h0};
        base = 8'hf0;
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys) nrst = 1;
        // Digits 5 and 8 carry mode bits and are left out
        for (int c = 0; c < 13; c++) if (c != 5 && c != 8) wr_dig(c[7:0], dv(c));
        for (int c = 0; c < 13; c++) if (c != 5 && c != 8) rd_dig(c[7:0], dv(c));
        cfg.wp_n = 0;
        wr_dig(8'h0c, 4'h9);
        cfg.wp_n = 1;
        rd_dig(8'h0c, 4'h0);
        rd_dig(8'h0d, 4'h0);
        xfer(1'b0, base + 8'h01, 8'h00);
        chk(32'(oe), 32'h0);
        $display("port test done");
        cfg.base_sw_n = 7'h55;
        base = 8'h54;
        xfer(1'b0, 8'hf0, 8'h00);
        chk(32'({oe, lo[7:0]}), 32'h0);
        wr_dig(8'h0b, 4'h2);
        rd_dig(8'h0b, 4'h2);
        $display("address test done");
        // Still frozen by the read just before, so the new digit stays hidden
        xfer(1'b1, base, 8'h07);
        xfer(1'b1, base + 8'h01, 8'h1b);
        rd_dig(8'h0b, 4'h2);
        xfer(1'b1, base + 8'h01, 8'h20);
        rd_dig(8'h0b, 4'h7);
        $display("freeze test done");
        for (int r = 0; r < 9; r++) tick(2'h3, r[3:0], 32);
        tick(2'h2, 4'h3, 512);
        $display("interrupt test done");
        give_verdict();
    end
endmodule
bind bpcci_top bpcci_top_checker #(.ACCESS_CYC(ACCESS_CYC)) u_bpcci_top_checker (.clk_sys(clk_sys), .nrst(nrst),
    .req(req), .cfg(cfg), .xtal_in(xtal_in), .rdata(rdata), .rdata_oe(rdata_oe), .rdy(rdy), .irq_vi(irq_vi),
    .irq_nmi(irq_nmi));

// >>> tb/bpcci_top_checker.sv
`timescale 1ns/100ps
module bpcci_top_checker #(
    parameter int unsigned ACCESS_CYC = 1500
) (
    input wire logic                  clk_sys,
    input wire logic                  nrst,
    input wire bpcci_pkg::bpcci_req_t req,
    input wire bpcci_pkg::bpcci_cfg_t cfg,
    input wire logic                  xtal_in,
    input wire logic [7:0]            rdata,
    input wire logic                  rdata_oe,
    input wire logic                  rdy,
    input wire logic [7:0]            irq_vi,
    input wire logic                  irq_nmi
);
    logic        hit;
    logic [15:0] lo_q;
    assign hit = req.addr[7:1] == ~cfg.base_sw_n;
    // Stall is too long to unroll, so it is counted
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lo_q <= 16'h0000;
        end else begin
            lo_q <= rdy ? 16'h0000 : lo_q + 16'h0001;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_dsel; $rose(req.rd) && hit && !req.addr[0] && rdy; endsequence
    sequence s_cwr; $rose(req.wr) && hit && req.addr[0] && rdy; endsequence
    property p_rd_stall; s_dsel |-> ##[1:2] !rdy; endproperty
    a_rd_stall: assert property (p_rd_stall) else $error("no stall on read");
    property p_len; $rose(rdy) |-> lo_q >= ACCESS_CYC - 1 && lo_q <= ACCESS_CYC + 1; endproperty
    a_len: assert property (p_len) else $error("bad stall length");
    property p_wcode; s_cwr ##0 req.wdata[7:4] == 4'h1 |-> ##[1:2] !rdy; endproperty
    a_wcode: assert property (p_wcode) else $error("no stall on write code");
    property p_sel; s_cwr ##0 req.wdata[7:4] == 4'h0 |-> rdy[*3]; endproperty
    a_sel: assert property (p_sel) else $error("select stalled");
    property p_miss; ($rose(req.rd) || $rose(req.wr)) && !hit |-> (rdy && !rdata_oe)[*3]; endproperty
    a_miss: assert property (p_miss) else $error("answered foreign port");
    property p_oe; rdata_oe |-> $past(req.rd) && !$past(req.addr[0]) && $past(hit); endproperty
    a_oe: assert property (p_oe) else $error("data driven without read");
    property p_cro; $rose(req.rd) && hit && req.addr[0] |=> !rdata_oe[*2]; endproperty
    a_cro: assert property (p_cro) else $error("control port read back");
    property p_lvl; (|irq_vi) && $stable(cfg) |-> !cfg.irq_route[3] && irq_vi == 8'h01 << cfg.irq_route[2:0];
    endproperty
    a_lvl: assert property (p_lvl) else $error("wrong level");
    property p_nmi; irq_nmi && $stable(cfg) |-> cfg.irq_route[3] ##1 !irq_nmi; endproperty
    a_nmi: assert property (p_nmi) else $error("bad nmi pulse");
endmodule
